// *** hdl/ast_regs.vh ***
// Register map, field positions and constants of the serial interface.
`ifndef AST_REGS_VH
`define AST_REGS_VH

// Word indices; the byte address is four times the index.
`define AST_IDX_CTRL1 6'h13
`define AST_IDX_CTRL2 6'h14
`define AST_IDX_CTRL3 6'h15
`define AST_IDX_STAT1 6'h16
`define AST_IDX_STAT2 6'h17
`define AST_IDX_DATA  6'h18
`define AST_IDX_BAUD  6'h19
`define AST_IDX_ISTAT 6'h1a
`define AST_IDX_IMASK 6'h1b

// Control one fields.
`define AST_C1_EN   6
`define AST_C1_INV  5
`define AST_C1_M    4
// Control two fields.
`define AST_C2_TIE  7
`define AST_C2_TCIE 6
`define AST_C2_RIE  5
`define AST_C2_TE   3
`define AST_C2_RE   2
`define AST_C2_SBK  0
// Control three fields.
`define AST_C3_R8   7
`define AST_C3_T8   6
`define AST_C3_WMSK 8'h4f
// Baud select fields.
`define AST_BAUD_WMSK 8'h37
`define AST_PRE_HI  5
`define AST_PRE_LO  4
`define AST_DIV_HI  2

// Reset values.
`define AST_CTRL_RST 8'h00
`define AST_BAUD_RST 8'h00

// Sticky interrupt status bit positions.
`define AST_EV_TBE 0
`define AST_EV_TC  1
`define AST_EV_RF  2
`define AST_EV_NF  3

// Bit timing in ticks of the sampling clock; frame lengths in bits.
`define AST_TICK_LAST 4'hf
`define AST_SMP_A     4'h7
`define AST_SMP_B     4'h8
`define AST_SMP_C     4'h9
`define AST_LEN8      4'ha
`define AST_LEN9      4'hb
`endif

// *** hdl/ast_baud_gen.v ***
// Shared baud generator producing the sixteen-times sampling tick.
`timescale 1ns/1ps
`include "ast_regs.vh"

module ast_baud_gen #(
   parameter BASE_DIV = 1
) (
   pclk,
   presetn,
   run,
   baud_sel,
   tick
);
   input  wire       pclk;
   input  wire       presetn;
   input  wire       run;
   input  wire [7:0] baud_sel;
   output reg        tick;

   reg  [15:0] cnt_q;
   wire [15:0] pre;
   wire [31:0] lim_w;
   wire [15:0] lim;

   // Prescale 1..4 times a power of two 1..128 gives 32 settings but only 18 distinct rates.
   assign pre   = {14'h0000, baud_sel[`AST_PRE_HI:`AST_PRE_LO]} + 16'h0001;
   // The product is formed wide and cut to the counter's width on purpose.
   assign lim_w = ((pre << baud_sel[`AST_DIV_HI:0]) * BASE_DIV) - 32'h0000_0001;
   assign lim   = lim_w[15:0];

   // Divider counter; one pulse each time it wraps.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 16'h0000;
         tick  <= 1'b0;
      end else if (!run) begin
         cnt_q <= 16'h0000;
         tick  <= 1'b0;
      end else if (cnt_q >= lim) begin
         cnt_q <= 16'h0000;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
         tick  <= 1'b0;
      end
   end
endmodule

// *** hdl/ast_serial_tx.v ***
// Asynchronous serial interface with APB registers and transmit path.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "ast_regs.vh"

module ast_serial_tx #(
   parameter BASE_DIV = 1
) (
   pclk,
   presetn,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   port_pin_zero_o,
   port_pin_zero_oe,
   port_pin_one_i,
   pins_owned,
   tx_irq,
   rx_irq,
   irq
);
   input  wire        pclk;
   input  wire        presetn;
   input  wire        psel;
   input  wire        penable;
   input  wire        pwrite;
   input  wire [7:0]  paddr;
   input  wire [31:0] pwdata;
   output reg  [31:0] prdata;
   output reg         pready;
   output reg         pslverr;
   output reg         port_pin_zero_o;
   output reg         port_pin_zero_oe;
   input  wire        port_pin_one_i;
   output reg         pins_owned;
   output reg         tx_irq;
   output reg         rx_irq;
   output reg         irq;

   localparam TX_IDLE  = 1'b0;
   localparam TX_SHIFT = 1'b1;
   localparam RX_IDLE  = 1'b0;
   localparam RX_RECV  = 1'b1;

   // True when the word address selects the given register index.
   function hit;
      input [7:0] a;
      input [5:0] idx;
      begin
         hit = (a[7:2] == idx);
      end
   endfunction

   // Frame length in bits, start and stop included.
   function [3:0] frame_len;
      input m;
      begin
         frame_len = m ? `AST_LEN9 : `AST_LEN8;
      end
   endfunction

   reg  [7:0]  ctrl1_q;
   reg  [7:0]  ctrl2_q;
   reg  [7:0]  ctrl3_q;
   reg  [7:0]  baud_q;
   reg  [7:0]  txbuf_q;
   reg  [3:0]  ist_q;
   reg  [3:0]  imask_q;
   reg         tbe_q;
   reg         tc_q;
   reg         armed_q;
   reg         te_prev_q;
   reg         sbk_prev_q;
   reg         pre_q;
   reg         tx_st_q;
   reg  [10:0] tsh_q;
   reg  [3:0]  tbits_q;
   reg  [3:0]  tsub_q;
   reg         rx_s1_q;
   reg         rx_s2_q;
   reg         rx_s3_q;
   reg         rx_st_q;
   reg  [3:0]  rsub_q;
   reg  [3:0]  rbits_q;
   reg  [9:0]  rsh_q;
   reg  [2:0]  rsmp_q;
   reg         rnoise_q;
   reg  [8:0]  rxbuf_q;
   reg         rf_q;
   reg         nf_q;
   reg         rarmed_q;
   reg  [7:0]  rd_mux;
   reg         mapped;
   wire        tick;
   wire        acc;
   wire        done;
   wire        wr;
   wire        rd;
   wire        en;
   wire        inv;
   wire        m9;
   wire        te;
   wire        sbk;
   wire        tx_go;
   wire        ld_pre;
   wire        ld_brk;
   wire        ld_dat;
   wire        bit_end;
   wire        last_bit;
   wire        dat_wr;
   wire [7:0]  stat1;
   wire [3:0]  ev;
   wire        rx_bit;
   wire        maj;
   wire        r_end;
   wire        r_last;

   assign en  = ctrl1_q[`AST_C1_EN];
   assign inv = ctrl1_q[`AST_C1_INV];
   assign m9  = ctrl1_q[`AST_C1_M];
   assign te  = ctrl2_q[`AST_C2_TE];
   assign sbk = ctrl2_q[`AST_C2_SBK];

   // ****************************************************************
   // APB slave: one wait state, then a registered answer.
   // ****************************************************************

   assign acc  = psel & penable;
   assign done = acc & pready;
   assign wr   = done & pwrite;
   assign rd   = done & ~pwrite;

   assign stat1 = {tbe_q, tc_q, rf_q, 2'b00, nf_q, 2'b00};

   // Read multiplexer and address decode.
   always @* begin
      mapped = 1'b1;
      rd_mux = 8'h00;
      if (hit(paddr, `AST_IDX_CTRL1)) begin
         rd_mux = ctrl1_q;
      end else if (hit(paddr, `AST_IDX_CTRL2)) begin
         rd_mux = ctrl2_q;
      end else if (hit(paddr, `AST_IDX_CTRL3)) begin
         rd_mux = {rxbuf_q[8], ctrl3_q[6:0]};
      end else if (hit(paddr, `AST_IDX_STAT1)) begin
         rd_mux = stat1;
      end else if (hit(paddr, `AST_IDX_STAT2)) begin
         rd_mux = 8'h00;
      end else if (hit(paddr, `AST_IDX_DATA)) begin
         rd_mux = rxbuf_q[7:0];
      end else if (hit(paddr, `AST_IDX_BAUD)) begin
         rd_mux = baud_q;
      end else if (hit(paddr, `AST_IDX_ISTAT)) begin
         rd_mux = {4'h0, ist_q};
      end else if (hit(paddr, `AST_IDX_IMASK)) begin
         rd_mux = {4'h0, imask_q};
      end else begin
         mapped = 1'b0;
      end
   end

   // Answer is raised in the second access cycle and held one cycle.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= acc & ~pready;
         pslverr <= acc & ~pready & ~mapped;
         if (acc & ~pready & ~pwrite) begin
            prdata <= {24'h00_0000, rd_mux};
         end
      end
   end

   // Writable control, baud and mask registers.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl1_q <= `AST_CTRL_RST;
         ctrl2_q <= `AST_CTRL_RST;
         ctrl3_q <= `AST_CTRL_RST;
         baud_q  <= `AST_BAUD_RST;
         imask_q <= 4'h0;
      end else if (wr) begin
         if (hit(paddr, `AST_IDX_CTRL1)) begin
            ctrl1_q <= pwdata[7:0];
         end
         if (hit(paddr, `AST_IDX_CTRL2)) begin
            ctrl2_q <= pwdata[7:0];
         end
         if (hit(paddr, `AST_IDX_CTRL3)) begin
            ctrl3_q <= pwdata[7:0] & `AST_C3_WMSK;
         end
         if (hit(paddr, `AST_IDX_BAUD)) begin
            baud_q <= pwdata[7:0] & `AST_BAUD_WMSK;
         end
         if (hit(paddr, `AST_IDX_IMASK)) begin
            imask_q <= pwdata[3:0];
         end
      end
   end

   // ****************************************************************
   // Shared baud generator.
   // ****************************************************************

   // Both directions count the same tick.
   ast_baud_gen #(
      .BASE_DIV (BASE_DIV)
   ) u_baud (
      .pclk     (pclk),
      .presetn  (presetn),
      .run      (en),
      .baud_sel (baud_q),
      .tick     (tick)
   );

   // ****************************************************************
   // Transmit buffer and its flags.
   // ****************************************************************

   assign dat_wr = wr & hit(paddr, `AST_IDX_DATA);

   // Buffer write and the status-then-data clear sequence.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txbuf_q <= 8'h00;
         armed_q <= 1'b0;
         tbe_q   <= 1'b1;
      end else begin
         if (dat_wr) begin
            txbuf_q <= pwdata[7:0];
         end
         if (rd & hit(paddr, `AST_IDX_STAT1)) begin
            armed_q <= 1'b1;
         end else if (dat_wr) begin
            armed_q <= 1'b0;
         end
         if (ld_dat) begin
            tbe_q <= 1'b1;
         end else if (dat_wr & armed_q) begin
            tbe_q <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Transmit shifter.
   // ****************************************************************

   assign tx_go   = en & te & (tx_st_q == TX_IDLE);
   assign ld_pre  = tx_go & pre_q;
   assign ld_brk  = tx_go & ~pre_q & sbk;
   assign ld_dat  = tx_go & ~pre_q & ~sbk & ~tbe_q;
   assign bit_end = tick & (tsub_q == `AST_TICK_LAST);
   assign last_bit = (tbits_q == 4'h1);

   // A preamble is queued when the transmitter turns on or break ends.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         te_prev_q  <= 1'b0;
         sbk_prev_q <= 1'b0;
         pre_q      <= 1'b0;
      end else begin
         te_prev_q  <= te & en;
         sbk_prev_q <= sbk;
         if ((te & en & ~te_prev_q) | (sbk_prev_q & ~sbk)) begin
            pre_q <= 1'b1;
         end else if (ld_pre) begin
            pre_q <= 1'b0;
         end
      end
   end

   // Load, shift once per sixteen ticks, return to idle at the end.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_q <= TX_IDLE;
         tsh_q   <= 11'h7ff;
         tbits_q <= 4'h0;
         tsub_q  <= 4'h0;
      end else if (!en) begin
         tx_st_q <= TX_IDLE;
         tsub_q  <= 4'h0;
      end else begin
         case (tx_st_q)
            TX_IDLE: begin
               tsub_q  <= 4'h0;
               tbits_q <= frame_len(m9);
               if (ld_pre) begin
                  tsh_q   <= 11'h7ff;
                  tx_st_q <= TX_SHIFT;
               end else if (ld_brk) begin
                  tsh_q   <= 11'h000;
                  tx_st_q <= TX_SHIFT;
               end else if (ld_dat) begin
                  // Stop one on top, start zero at the bottom.
                  tsh_q   <= {1'b1, (m9 ? ctrl3_q[`AST_C3_T8] : 1'b1),
                              txbuf_q, 1'b0};
                  tx_st_q <= TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               if (tick) begin
                  tsub_q <= tsub_q + 4'h1;
               end
               if (bit_end) begin
                  tsh_q   <= {1'b1, tsh_q[10:1]};
                  tbits_q <= tbits_q - 4'h1;
                  if (last_bit) begin
                     tx_st_q <= TX_IDLE;
                  end
               end
            end
            default: begin
               tx_st_q <= TX_IDLE;
            end
         endcase
      end
   end

   // Pin drive: idle one, inverted on request, released when disabled.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_pin_zero_o  <= 1'b1;
         port_pin_zero_oe <= 1'b0;
         pins_owned       <= 1'b0;
      end else begin
         port_pin_zero_o  <= ((tx_st_q == TX_SHIFT) ? tsh_q[0] : 1'b1)
                             ^ inv;
         port_pin_zero_oe <= en;
         pins_owned       <= en;
      end
   end

   // Complete when buffer and shifter are empty and nothing is queued.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tc_q <= 1'b1;
      end else begin
         tc_q <= tbe_q & (tx_st_q == TX_IDLE) & ~pre_q & ~sbk;
      end
   end

   // ****************************************************************
   // Receiver with three-sample noise check.
   // ****************************************************************

   // Two-stage synchroniser, plus a third stage for edge detection.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_s1_q <= 1'b1;
         rx_s2_q <= 1'b1;
         rx_s3_q <= 1'b1;
      end else begin
         rx_s1_q <= port_pin_one_i;
         rx_s2_q <= rx_s1_q;
         rx_s3_q <= rx_s2_q;
      end
   end

   assign rx_bit = rx_s2_q;
   assign maj    = (rsmp_q[0] & rsmp_q[1]) | (rsmp_q[1] & rsmp_q[2]) |
                   (rsmp_q[0] & rsmp_q[2]);
   assign r_end  = tick & (rsub_q == `AST_TICK_LAST);
   assign r_last = (rbits_q == 4'h1);

   // Receive state machine, sampling ticks seven, eight and nine.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st_q  <= RX_IDLE;
         rsub_q   <= 4'h0;
         rbits_q  <= 4'h0;
         rsh_q    <= 10'h000;
         rsmp_q   <= 3'h7;
         rnoise_q <= 1'b0;
      end else if (!(en & ctrl2_q[`AST_C2_RE])) begin
         rx_st_q <= RX_IDLE;
      end else begin
         case (rx_st_q)
            RX_IDLE: begin
               rsub_q   <= 4'h0;
               rnoise_q <= 1'b0;
               rbits_q  <= frame_len(m9);
               if (rx_s3_q & ~rx_bit) begin
                  rx_st_q <= RX_RECV;
               end
            end
            RX_RECV: begin
               if (tick) begin
                  rsub_q <= rsub_q + 4'h1;
                  if (rsub_q == `AST_SMP_A) begin
                     rsmp_q[0] <= rx_bit;
                  end
                  if (rsub_q == `AST_SMP_B) begin
                     rsmp_q[1] <= rx_bit;
                  end
                  if (rsub_q == `AST_SMP_C) begin
                     rsmp_q[2] <= rx_bit;
                  end
               end
               if (r_end) begin
                  rsh_q   <= {maj, rsh_q[9:1]};
                  rbits_q <= rbits_q - 4'h1;
                  if (rsmp_q != 3'h0 && rsmp_q != 3'h7) begin
                     rnoise_q <= 1'b1;
                  end
                  if (r_last) begin
                     rx_st_q <= RX_IDLE;
                  end
               end
            end
            default: begin
               rx_st_q <= RX_IDLE;
            end
         endcase
      end
   end

   // Receive buffer and flags, cleared by status read then data read.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxbuf_q  <= 9'h000;
         rf_q     <= 1'b0;
         nf_q     <= 1'b0;
         rarmed_q <= 1'b0;
      end else begin
         if (rd & hit(paddr, `AST_IDX_STAT1)) begin
            rarmed_q <= 1'b1;
         end else if (rd & hit(paddr, `AST_IDX_DATA)) begin
            rarmed_q <= 1'b0;
         end
         if ((rx_st_q == RX_RECV) & r_end & r_last) begin
            rxbuf_q <= m9 ? rsh_q[9:1] : {1'b0, rsh_q[9:2]};
            rf_q    <= 1'b1;
            nf_q    <= rnoise_q | (rsmp_q != 3'h0 && rsmp_q != 3'h7);
         end else if (rd & hit(paddr, `AST_IDX_DATA) & rarmed_q) begin
            rf_q <= 1'b0;
            nf_q <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Interrupts.
   // ****************************************************************

   assign ev = {(rx_st_q == RX_RECV) & r_end & r_last &
                (rnoise_q | (rsmp_q != 3'h0 && rsmp_q != 3'h7)),
                (rx_st_q == RX_RECV) & r_end & r_last,
                tbe_q & ~tc_q & (tx_st_q == TX_IDLE) & ~pre_q & ~sbk,
                ld_dat};

   // Sticky status, write one to clear; a new event beats the clear.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_q <= 4'h0;
      end else if (wr & hit(paddr, `AST_IDX_ISTAT)) begin
         ist_q <= (ist_q & ~pwdata[3:0]) | ev;
      end else begin
         ist_q <= ist_q | ev;
      end
   end

   // Separate transmit and receive requests plus the masked summary.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_irq <= 1'b0;
         rx_irq <= 1'b0;
         irq    <= 1'b0;
      end else begin
         tx_irq <= (tbe_q & ctrl2_q[`AST_C2_TIE]) |
                   (tc_q & ctrl2_q[`AST_C2_TCIE]);
         rx_irq <= rf_q & ctrl2_q[`AST_C2_RIE];
         irq    <= |(ist_q & imask_q);
      end
   end
endmodule

// *** tb/ast_serial_tx_asserts.sv ***
// Port-level assertion checker for the serial interface.
`timescale 1ns/1ps
module ast_chk #(parameter BASE_DIV = 1) (
   input wire logic        pclk, presetn, psel, penable, pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic        pready, pslverr, port_pin_zero_o, port_pin_zero_oe,
   input wire logic        port_pin_one_i, pins_owned, tx_irq, rx_irq, irq
);
   // ****
   // Shadow state and checks
   // ****
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic        acc;
   logic [5:0]  idx;
   logic        inv_q, te_q, tie_q, tcie_q, rie_q;
   logic [7:0]  baud_q;
   logic [15:0] cnt_q, blen;
   assign acc = psel && penable && pready;
   assign idx = paddr[7:2];
   assign blen = 16'(BASE_DIV * 16 * (baud_q[5:4] + 1)) << baud_q[2:0];
   // Control and baud fields copied from each accepted write to their own registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {inv_q, te_q, tie_q, tcie_q, rie_q} <= 5'h00;
         baud_q <= 8'h00;
      end else if (acc && pwrite) begin
         if (idx == 6'h13) inv_q <= pwdata[5];
         if (idx == 6'h14) {tie_q, tcie_q, rie_q, te_q} <= {pwdata[7:5], pwdata[3]};
         if (idx == 6'h19) baud_q <= pwdata[7:0] & 8'h37;
      end
   end
   // Counts how long the owned serial level has held, so short bits show up.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_q <= 16'h0000;
      else if (!port_pin_zero_oe || $changed(port_pin_zero_o)) cnt_q <= 16'h0000;
      else if (cnt_q != 16'hffff) cnt_q <= cnt_q + 16'h0001;
   end
   property p_pready_pulse;
      pready |=> !pready;
   endproperty
   a_pready_pulse: assert property (p_pready_pulse) else $error("ready held too long");
   property p_err_map;
      acc |-> pslverr == (idx < 6'h13 || idx > 6'h1b);
   endproperty
   a_err_map: assert property (p_err_map) else $error("error response wrong");
   property p_rd_zero;
      acc && !pwrite |-> prdata[31:8] == 24'h000000;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("upper read bits set");
   property p_release;
      acc && pwrite && idx == 6'h13 && !pwdata[6] |->
         ##[1:2] !port_pin_zero_oe ##[0:1] !pins_owned;
   endproperty
   a_release: assert property (p_release) else $error("pin not released");
   property p_own;
      $rose(port_pin_zero_oe) |-> ##[0:1] pins_owned;
   endproperty
   a_own: assert property (p_own) else $error("ownership flag late");
   property p_bit_len;
      port_pin_zero_oe && $past(port_pin_zero_oe) && $changed(port_pin_zero_o)
         && inv_q == $past(inv_q, 3) |-> cnt_q >= blen - (blen >> 4);
   endproperty
   a_bit_len: assert property (p_bit_len) else $error("bit too short");
   property p_idle;
      port_pin_zero_oe && !te_q && inv_q == $past(inv_q, 2) |-> port_pin_zero_o == !inv_q;
   endproperty
   a_idle: assert property (p_idle) else $error("idle level wrong");
   property p_txirq;
      !tie_q && !tcie_q && !$past(tie_q) && !$past(tcie_q) |-> !tx_irq;
   endproperty
   a_txirq: assert property (p_txirq) else $error("transmit request unmasked");
   property p_rxirq;
      !rie_q && !$past(rie_q) |-> !rx_irq;
   endproperty
   a_rxirq: assert property (p_rxirq) else $error("receive request unmasked");
   c_disable: cover property ($fell(port_pin_zero_oe));
   c_txirq: cover property ($rose(tx_irq));
   c_err: cover property (acc && pslverr);
endmodule
bind ast_serial_tx ast_chk #(.BASE_DIV(BASE_DIV)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_pin_zero_o(port_pin_zero_o),
   .port_pin_zero_oe(port_pin_zero_oe), .port_pin_one_i(port_pin_one_i),
   .pins_owned(pins_owned), .tx_irq(tx_irq), .rx_irq(rx_irq), .irq(irq));

// *** tb/ast_far_end.sv ***
// Behavioural remote station that decodes frames seen on the serial line.
`timescale 1ns/1ps
module ast_far_end (
   input  wire logic        pclk, line, inv, nine,
   input  wire logic [15:0] bit_cyc,
   output logic             rx_pin, rx_stop,
   output logic [8:0]       rx_data,
   output int               rx_cnt
);
   int i;
   // Echoes the decoded line level back, so the block's receiver hears its own frames.
   always @(posedge pclk) rx_pin <= line ^ inv;
   // A start is taken only if it still holds at mid-bit, so glitches are ignored.
   initial begin
      rx_data = 9'h000;
      rx_stop = 1'b0;
      rx_cnt = 0;
      forever begin
         @(posedge pclk);
         if ((line ^ inv) === 1'b0) begin
            repeat (bit_cyc / 2) @(posedge pclk);
            if ((line ^ inv) === 1'b0) begin
               rx_data = 9'h000;
               for (i = 0; i < (nine ? 9 : 8); i++) begin
                  repeat (bit_cyc) @(posedge pclk);
                  rx_data[i] = line ^ inv;
               end
               repeat (bit_cyc) @(posedge pclk);
               rx_stop = line ^ inv;
               rx_cnt++;
               while ((line ^ inv) !== 1'b1) @(posedge pclk);
            end
         end
      end
   end
endmodule

// *** tb/tb_ast_serial_tx.sv ***
// Self-checking testbench for the serial interface.
`timescale 1ns/1ps
module tb_ast_serial_tx;
   logic        pclk = 1'b0, presetn, psel, penable, pwrite, rerr, rx_stop;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic        pready, pslverr, pin_o, pin_oe, rx_pin, owned, tx_irq, rx_irq, irq;
   logic        inv_m, nine_m;
   logic [8:0]  rx_data;
   logic [15:0] bitc;
   wire         ser_line = pin_oe ? pin_o : 1'b1;
   int          failures = 0, tests_run = 0, rx_cnt, lat;
   // ****
   // Clock, design and remote station
   // ****
   always #50 pclk = ~pclk;
   ast_serial_tx #(.BASE_DIV(1)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .port_pin_zero_o(pin_o),
      .port_pin_zero_oe(pin_oe), .port_pin_one_i(rx_pin), .pins_owned(owned),
      .tx_irq(tx_irq), .rx_irq(rx_irq), .irq(irq));
   ast_far_end u_far (.pclk(pclk), .line(ser_line), .inv(inv_m), .nine(nine_m),
      .bit_cyc(bitc), .rx_pin(rx_pin), .rx_stop(rx_stop), .rx_data(rx_data), .rx_cnt(rx_cnt));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   // One register transfer; an idle edge follows so requests never collide.
   task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic do_reset();
      presetn <= 1'b0;
      inv_m <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask
   // Hands one character over and judges the decoded frame; lat is the start delay.
   task automatic send(input logic [7:0] d, input logic [8:0] exp);
      int c0;
      int i;
      c0 = rx_cnt;
      apb(1'b0, 6'h16, 32'h0);
      apb(1'b1, 6'h18, {24'h0, d});
      for (lat = 0; lat < 2000 && ser_line !== inv_m; lat++) @(posedge pclk);
      for (i = 0; i < 5000 && rx_cnt == c0; i++) @(posedge pclk);
      chk(rx_cnt, c0 + 1);
      chk(rx_data, exp);
      chk(rx_stop, 1'b1);
   endtask
   task automatic t_regs();
      do_reset();
      apb(1'b0, 6'h13, 32'h0);
      chk(rdat, 32'h0);
      apb(1'b0, 6'h16, 32'h0);
      chk(rdat & 32'hc0, 32'hc0);
      apb(1'b1, 6'h19, 32'hff);
      apb(1'b0, 6'h19, 32'h0);
      chk(rdat, 32'h37);
      apb(1'b0, 6'h3f, 32'h0);
      chk(rerr, 1'b1);
      $display("regs done");
   endtask
   task automatic t_frame8();
      do_reset();
      apb(1'b1, 6'h13, 32'h40);
      apb(1'b1, 6'h14, 32'h2c);
      send(8'ha5, 9'h0a5);
      chk(lat > 100, 1'b1);
      // The echoed frame lands in the receiver a few cycles after its stop bit.
      repeat (20) @(posedge pclk);
      chk(rx_irq, 1'b1);
      apb(1'b0, 6'h16, 32'h0);
      chk(rdat & 32'h24, 32'h20);
      apb(1'b0, 6'h18, 32'h0);
      chk(rdat, 32'ha5);
      send(8'h3c, 9'h03c);
      chk(lat < 20, 1'b1);
      apb(1'b0, 6'h16, 32'h0);
      chk(rdat[7], 1'b1);
      apb(1'b1, 6'h1b, 32'h1);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1);
      apb(1'b1, 6'h1a, 32'h1);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      $display("frame8 done");
   endtask
   task automatic t_nine();
      do_reset();
      nine_m <= 1'b1;
      apb(1'b1, 6'h13, 32'h50);
      apb(1'b1, 6'h15, 32'h40);
      apb(1'b1, 6'h14, 32'h08);
      send(8'h3c, 9'h13c);
      apb(1'b1, 6'h15, 32'h00);
      send(8'hc3, 9'h0c3);
      nine_m <= 1'b0;
      $display("nine done");
   endtask
   task automatic t_inv();
      do_reset();
      apb(1'b1, 6'h13, 32'h40);
      inv_m <= 1'b1;
      apb(1'b1, 6'h13, 32'h60);
      repeat (3) @(posedge pclk);
      chk(pin_o, 1'b0);
      apb(1'b1, 6'h14, 32'h08);
      send(8'h5a, 9'h05a);
      $display("inv done");
   endtask
   task automatic t_irq();
      do_reset();
      apb(1'b1, 6'h13, 32'h40);
      apb(1'b1, 6'h14, 32'ha8);
      repeat (2) @(posedge pclk);
      chk(tx_irq, 1'b1);
      chk(rx_irq, 1'b0);
      apb(1'b1, 6'h14, 32'h08);
      repeat (2) @(posedge pclk);
      chk(tx_irq, 1'b0);
      $display("irq done");
   endtask
   task automatic t_disable();
      do_reset();
      apb(1'b1, 6'h13, 32'h40);
      apb(1'b1, 6'h14, 32'h08);
      apb(1'b0, 6'h16, 32'h0);
      apb(1'b1, 6'h18, 32'h0f);
      repeat (200) @(posedge pclk);
      chk(owned, 1'b1);
      apb(1'b1, 6'h13, 32'h00);
      repeat (2) @(posedge pclk);
      chk(pin_oe, 1'b0);
      chk(owned, 1'b0);
      repeat (200) @(posedge pclk);
      $display("disable done");
   endtask
   task automatic t_baud();
      do_reset();
      bitc <= 16'd32;
      apb(1'b1, 6'h19, 32'h01);
      apb(1'b1, 6'h13, 32'h40);
      apb(1'b1, 6'h14, 32'h08);
      send(8'h96, 9'h096);
      bitc <= 16'd16;
      $display("baud done");
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      {presetn, psel, penable, pwrite, inv_m, nine_m} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      bitc = 16'd16;
      t_regs();
      t_frame8();
      t_nine();
      t_inv();
      t_irq();
      t_disable();
      t_baud();
      end_sim();
   end
   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      $display("unexpected at %0t: watchdog expired", $time);
      end_sim();
   end
endmodule
